// ### src/bfsx_pkg.sv
// Purpose: shared constants and types of the bit/flag/stack execution unit
// Assumes: 8-bit datapath, status flags held inside the unit
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package bfsx_pkg;

  // operation codes of the instruction group
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_PUSH       = 5'h01,
    OP_POP        = 5'h02,
    OP_IO_SET     = 5'h03,
    OP_IO_CLR     = 5'h04,
    OP_SHIFT_LEFT = 5'h05,
    OP_SHIFT_RGHT = 5'h06,
    OP_ROT_LEFT   = 5'h07,
    OP_ROT_RGHT   = 5'h08,
    OP_ARITH_RGHT = 5'h09,
    OP_SWAP       = 5'h0a,
    OP_BIT_TO_T   = 5'h0b,
    OP_T_TO_BIT   = 5'h0c,
    OP_FLAG_SET   = 5'h0d,
    OP_FLAG_CLR   = 5'h0e,
    OP_SLEEP      = 5'h0f,
    OP_WDOG       = 5'h10,
    OP_BREAK      = 5'h11
  } bfsx_op_t;

  // sequencer states, gray coded along idle -> second -> done
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SECOND = 2'b01,
    ST_DONE   = 2'b11
  } bfsx_state_t;

  // status flag positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // register byte addresses
  localparam logic [7:0] ADDR_CMD    = 8'h00; // write: issue instruction
  localparam logic [7:0] ADDR_FLAGS  = 8'h04; // status_flags_reg
  localparam logic [7:0] ADDR_RESULT = 8'h08; // last result byte
  localparam logic [7:0] ADDR_STATUS = 8'h0c; // busy bit and stack pointer
  localparam logic [7:0] ADDR_IO     = 8'h10; // io register file base
  localparam int unsigned IO_REGS    = 4;     // io registers reachable
  localparam int unsigned STACK_DEPTH = 8;    // stack entries

  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] IO_RST    = 8'h00;

  // timing of two-cycle instructions
  localparam int unsigned LONG_CYCLES = 2;

  // command word fields
  localparam int unsigned CMD_OP_LSB  = 0;  // 5-bit opcode
  localparam int unsigned CMD_BIT_LSB = 8;  // 3-bit bit select
  localparam int unsigned CMD_SEL_LSB = 12; // 2-bit io register select
  localparam int unsigned CMD_DAT_LSB = 16; // 8-bit operand

  // decoded instruction carrier
  typedef struct packed {
    bfsx_op_t   op;
    logic [2:0] bit_sel;
    logic [1:0] io_sel;
    logic [7:0] operand;
  } bfsx_instr_t;

endpackage : bfsx_pkg

// ### src/bfsx_exec_unit.sv
// Purpose: executes stack, io-bit, shift, flag and control instructions
// Assumes: one instruction in flight; commands written over apb
// Notes:   results and flags kept locally; control requests are pulses
//
// Behaviour
// - push copies source onto stack, two cycles
// - pop loads destination from stack, two cycles
// - io bit set, two cycles, flags kept
// - io bit clear, two cycles, flags kept
// - logical left shift updates Z,C,N,V
// - logical right shift updates Z,C,N,V
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - arithmetic right shift keeps top bit
// - swap nibbles, flags unchanged
// - copy register bit into transfer flag
// - write transfer flag into register bit
// - set or clear carry only
// - set or clear negative only
// - set or clear signed flag only
// - set or clear overflow only
// - set or clear half carry only
// - sleep request pulse, no flag change
// - watchdog restart pulse, no flag change
// - break acts only when debug active
//
// Usage
// - software issues one command word at a time through the command register
// - push, pop and io bit ops hold the unit busy for one extra cycle
// - a command written while busy is dropped; poll the busy bit first
// - shift and rotate ops also refresh the signed flag as N xor V
// - flag set and clear ops take the flag index from the bit field
// - the stack has eight entries and wraps silently on overflow
// - control requests are single-cycle pulses registered after issue
// - clock enable low freezes every register, apb writes included
`timescale 1ns/1ns
`default_nettype none

module bfsx_exec_unit (
  input  wire logic        clk_sys,      // 125 MHz core clock
  input  wire logic        nrst,         // synchronous reset, active low
  input  wire logic        clk_en,       // freezes all state when low
  input  wire logic        debug_active, // on-chip debugging enabled
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error, unmapped address
  output logic             sleep_req,    // one-cycle sleep request
  output logic             wdog_restart, // one-cycle watchdog restart
  output logic             break_req     // one-cycle debug break
);

  // internal state of the unit
  // everything below is flip-flop storage or combinational decode
  // the instruction latch keeps the command for the second cycle
  // of push, pop and io bit ops, so software may change pwdata
  // freely once the command write has been taken
  // decoded command
  bfsx_pkg::bfsx_instr_t   instr;        // instruction in flight
  bfsx_pkg::bfsx_state_t   state;        // sequencer state
  logic [7:0]              flags;        // status_flags_reg
  logic [7:0]              result;       // last result byte
  logic [7:0]              io_reg [bfsx_pkg::IO_REGS];    // io registers
  logic [7:0]              stack  [bfsx_pkg::STACK_DEPTH]; // stack storage
  logic [2:0]              sp;           // stack pointer, next free slot
  logic [7:0]              next_result;  // combinational result
  logic [7:0]              next_flags;   // combinational flags
  logic                    wr_result;    // result register updates
  logic                    issue;        // new command accepted
  logic                    apb_access;   // apb access phase
  logic                    addr_ok;      // mapped address
  bfsx_pkg::bfsx_instr_t   cmd;          // command decoded from pwdata

  // flags after a shift: Z, C, N and V = N xor C
  // shared by all five shift and rotate ops
  // S follows as N xor V, which reduces to the new carry
  // flags outside the arithmetic group pass through unchanged
  function automatic logic [7:0] shift_flags(input logic [7:0] f,
                                              input logic [7:0] r,
                                              input logic       c);
    logic [7:0] o;
    o = f;
    o[bfsx_pkg::FLAG_C] = c;
    o[bfsx_pkg::FLAG_Z] = (r == 8'h00);
    o[bfsx_pkg::FLAG_N] = r[7];
    o[bfsx_pkg::FLAG_V] = r[7] ^ c;
    o[bfsx_pkg::FLAG_S] = r[7] ^ (r[7] ^ c);
    return o;
  endfunction : shift_flags

  // io address index from byte address
  // one aligned word per io register, low byte used
  // only called once the address is known to be mapped
  // upper address bits are ignored after the subtraction
  function automatic logic [1:0] io_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - bfsx_pkg::ADDR_IO;
    return d[3:2];
  endfunction : io_index

  // apb decode
  // zero wait states: every access completes in its access phase
  // unmapped addresses answer with an error but change nothing
  // a command write is only taken while the sequencer is idle
  // reads never have side effects
  assign apb_access = psel && penable;
  assign pready     = 1'b1;
  assign addr_ok    = (paddr == bfsx_pkg::ADDR_CMD) || (paddr == bfsx_pkg::ADDR_FLAGS)
                   || (paddr == bfsx_pkg::ADDR_RESULT) || (paddr == bfsx_pkg::ADDR_STATUS)
                   || ((paddr >= bfsx_pkg::ADDR_IO) && (paddr < 8'h20) && (paddr[1:0] == 2'b00));
  assign pslverr    = apb_access && !addr_ok;
  // one assignment fills the whole carrier, field by field
  // unknown opcodes fall to the default branch and do nothing
  assign cmd = '{op:      bfsx_pkg::bfsx_op_t'(pwdata[bfsx_pkg::CMD_OP_LSB +: 5]),
                 bit_sel: pwdata[bfsx_pkg::CMD_BIT_LSB +: 3],
                 io_sel:  pwdata[bfsx_pkg::CMD_SEL_LSB +: 2],
                 operand: pwdata[bfsx_pkg::CMD_DAT_LSB +: 8]};
  // commands written while busy are dropped
  assign issue = apb_access && pwrite && (paddr == bfsx_pkg::ADDR_CMD)
              && (state == bfsx_pkg::ST_IDLE);

  // apb read mux
  // read data is zero outside a read access phase
  // byte registers sit in the low bits, upper bits read zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (apb_access && !pwrite)
    begin
      case (paddr)
        bfsx_pkg::ADDR_FLAGS:  prdata[7:0] = flags;
        bfsx_pkg::ADDR_RESULT: prdata[7:0] = result;
        bfsx_pkg::ADDR_STATUS: prdata[3:0] = {(state != bfsx_pkg::ST_IDLE), sp};
        default:
        begin
          if (addr_ok && paddr >= bfsx_pkg::ADDR_IO)
            prdata[7:0] = io_reg[io_index(paddr)];
        end
      endcase
    end
  end

  // one-cycle datapath of the instruction being issued
  // evaluated every cycle from pwdata; only used on issue
  // the operand field stands in for the register file value
  // two-cycle and control ops leave result and flags alone
  // flag ops change exactly one flag, picked by the bit field
  always_comb
  begin
    next_result = result;
    next_flags  = flags;
    wr_result   = 1'b0;
    case (cmd.op)
      // shift left, zero enters at the bottom
      bfsx_pkg::OP_SHIFT_LEFT:
      begin
        next_result = {cmd.operand[6:0], 1'b0};
        next_flags  = shift_flags(flags, next_result, cmd.operand[7]);
        wr_result   = 1'b1;
      end
      // shift right, zero enters at the top
      bfsx_pkg::OP_SHIFT_RGHT:
      begin
        next_result = {1'b0, cmd.operand[7:1]};
        next_flags  = shift_flags(flags, next_result, cmd.operand[0]);
        wr_result   = 1'b1;
      end
      // rotate left through the old carry
      bfsx_pkg::OP_ROT_LEFT:
      begin
        next_result = {cmd.operand[6:0], flags[bfsx_pkg::FLAG_C]};
        next_flags  = shift_flags(flags, next_result, cmd.operand[7]);
        wr_result   = 1'b1;
      end
      // rotate right through the old carry
      bfsx_pkg::OP_ROT_RGHT:
      begin
        next_result = {flags[bfsx_pkg::FLAG_C], cmd.operand[7:1]};
        next_flags  = shift_flags(flags, next_result, cmd.operand[0]);
        wr_result   = 1'b1;
      end
      // arithmetic shift right, sign bit kept
      bfsx_pkg::OP_ARITH_RGHT:
      begin
        next_result = {cmd.operand[7], cmd.operand[7:1]};
        next_flags  = shift_flags(flags, next_result, cmd.operand[0]);
        wr_result   = 1'b1;
      end
      bfsx_pkg::OP_SWAP:
      begin
        next_result = {cmd.operand[3:0], cmd.operand[7:4]};
        wr_result   = 1'b1;
      end
      bfsx_pkg::OP_BIT_TO_T:
        next_flags[bfsx_pkg::FLAG_T] = cmd.operand[cmd.bit_sel];
      bfsx_pkg::OP_T_TO_BIT:
      begin
        next_result = cmd.operand;
        next_result[cmd.bit_sel] = flags[bfsx_pkg::FLAG_T];
        wr_result   = 1'b1;
      end
      // bit_sel picks C,Z,N,V,S,H,T,I
      bfsx_pkg::OP_FLAG_SET:
        next_flags[cmd.bit_sel] = 1'b1;
      bfsx_pkg::OP_FLAG_CLR:
        next_flags[cmd.bit_sel] = 1'b0;
      default:
      begin
        next_result = result; // nop, stack, io and control ops
      end
    endcase
  end

  // sequencer: single-cycle ops stay idle, two-cycle ops pass second
  // busy lasts exactly one cycle after the command edge
  // the done code is never entered; default recovers to idle
  // reset and clock enable gate every transition
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      state <= bfsx_pkg::ST_IDLE;
    else if (clk_en)
    begin
      case (state)
        bfsx_pkg::ST_IDLE:
          if (issue && (cmd.op == bfsx_pkg::OP_PUSH || cmd.op == bfsx_pkg::OP_POP
                     || cmd.op == bfsx_pkg::OP_IO_SET || cmd.op == bfsx_pkg::OP_IO_CLR))
            state <= bfsx_pkg::ST_SECOND;
        bfsx_pkg::ST_SECOND:
          state <= bfsx_pkg::ST_IDLE;     // second of the two cycles
        default:
          state <= bfsx_pkg::ST_IDLE;
      endcase
    end
  end

  // instruction latch
  // holds the command while the second cycle runs
  // updated on every accepted command, not only two-cycle ones
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      instr <= '0;
    else if (clk_en && issue)
      instr <= cmd;
  end

  // status flags: written by flag ops and shifts, or by software
  // command and flag writes use different addresses,
  // so both can never land at one edge
  // stack and io ops leave the flags untouched
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      flags <= bfsx_pkg::FLAGS_RST;
    else if (clk_en)
    begin
      if (issue)
        flags <= next_flags;
      else if (apb_access && pwrite && paddr == bfsx_pkg::ADDR_FLAGS)
        flags <= pwdata[7:0];
    end
  end

  // result byte: one-cycle ops now, pop at end of second cycle
  // the pointer has already stepped down when the pop reads
  // bit transfer into the flag leaves the result alone
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      result <= 8'h00;
    else if (clk_en)
    begin
      if (issue && wr_result)
        result <= next_result;
      else if (state == bfsx_pkg::ST_SECOND && instr.op == bfsx_pkg::OP_POP)
        result <= stack[sp];
    end
  end

  // stack pointer and storage, flags never touched
  // pointer names the next free slot
  // pop steps down at issue so the second cycle reads the top
  // push writes the slot, then steps up; both wrap at eight
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      sp <= 3'h0;
    else if (clk_en && issue && cmd.op == bfsx_pkg::OP_POP)
      sp <= sp - 3'h1;
    else if (clk_en && state == bfsx_pkg::ST_SECOND && instr.op == bfsx_pkg::OP_PUSH)
      sp <= sp + 3'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < bfsx_pkg::STACK_DEPTH; i++)
        stack[i] <= 8'h00;
    end
    else if (clk_en && state == bfsx_pkg::ST_SECOND && instr.op == bfsx_pkg::OP_PUSH)
      stack[sp] <= instr.operand;
  end

  // io registers: software writes or read-modify-write bit ops
  // the bit op in its second cycle wins over a software write
  // only the addressed bit changes, the other seven are kept
  // flags are never touched from here
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < bfsx_pkg::IO_REGS; i++)
        io_reg[i] <= bfsx_pkg::IO_RST;
    end
    else if (clk_en)
    begin
      if (state == bfsx_pkg::ST_SECOND && instr.op == bfsx_pkg::OP_IO_SET)
        io_reg[instr.io_sel][instr.bit_sel] <= 1'b1;
      else if (state == bfsx_pkg::ST_SECOND && instr.op == bfsx_pkg::OP_IO_CLR)
        io_reg[instr.io_sel][instr.bit_sel] <= 1'b0;
      else if (apb_access && pwrite && addr_ok && paddr >= bfsx_pkg::ADDR_IO)
        io_reg[io_index(paddr)] <= pwdata[7:0];
    end
  end

  // control pulses, one cycle after issue
  // each pulse stands exactly one cycle and changes no flag
  // sleep and watchdog effects belong to blocks outside this unit
  // break is dropped silently unless debugging is active
  // registered so the outputs are free of decode glitches
  // clock enable low holds the current pulse value
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sleep_req    <= 1'b0;
      wdog_restart <= 1'b0;
      break_req    <= 1'b0;
    end
    else if (clk_en)
    begin
      sleep_req    <= issue && cmd.op == bfsx_pkg::OP_SLEEP;
      wdog_restart <= issue && cmd.op == bfsx_pkg::OP_WDOG;
      break_req    <= issue && cmd.op == bfsx_pkg::OP_BREAK && debug_active;
    end
  end

  // limitation: the stack does not flag overflow or underflow;
  // software keeps track of its own depth
  // limitation: io registers beyond the fourth are unmapped

endmodule : bfsx_exec_unit

`default_nettype wire

// ### verification/bfsx_exec_unit_properties.sv
// Purpose: port-level properties of the execution unit
// Assumes: zero-wait apb slave, control pulses one cycle after the command edge
// Notes:   bound into every instance of the unit
`timescale 1ns/1ns
`default_nettype none

module bfsx_exec_unit_properties (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        debug_active,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleep_req,
  input wire logic        wdog_restart,
  input wire logic        break_req
);
  logic       cmd_wr; // command write seen at this edge, also while the unit is busy
  logic [4:0] cmd_op; // opcode field of the write data
  assign cmd_wr = psel && penable && pwrite && (paddr == bfsx_pkg::ADDR_CMD) && clk_en;
  assign cmd_op = pwdata[4:0];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // command write with a given opcode, not right behind another one
  sequence s_cmd(logic [4:0] o);
    cmd_wr && (cmd_op == o) ##0 !$past(cmd_wr, 2);
  endsequence

  a_ready_high: assert property (pready) else $error("ready low");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
  a_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data not zero");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h1f |-> pslverr)
    else $error("no error on unmapped address");
  a_sleep_cause: assert property (sleep_req |-> $past(cmd_wr) && $past(cmd_op) == bfsx_pkg::OP_SLEEP)
    else $error("stray sleep pulse");
  a_wdog_cause: assert property (wdog_restart |-> $past(cmd_wr) && $past(cmd_op) == bfsx_pkg::OP_WDOG)
    else $error("stray watchdog pulse");
  a_break_cause: assert property (break_req |-> $past(cmd_wr) && $past(debug_active)
    && $past(cmd_op) == bfsx_pkg::OP_BREAK)
    else $error("stray break pulse");
  a_sleep_issue: assert property (s_cmd(bfsx_pkg::OP_SLEEP) |=> sleep_req ##1 !sleep_req)
    else $error("sleep pulse wrong");
  a_wdog_issue: assert property (s_cmd(bfsx_pkg::OP_WDOG) |=> wdog_restart ##1 !wdog_restart)
    else $error("watchdog pulse wrong");
  a_break_gated: assert property (s_cmd(bfsx_pkg::OP_BREAK) |=> break_req == $past(debug_active))
    else $error("break not gated by debug");
endmodule : bfsx_exec_unit_properties

bind bfsx_exec_unit bfsx_exec_unit_properties i_props (.clk_sys(clk_sys), .nrst(nrst),
  .clk_en(clk_en), .debug_active(debug_active), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_req(sleep_req), .wdog_restart(wdog_restart), .break_req(break_req));
`default_nettype wire

// ### verification/test_bfsx_exec_unit.sv
// Purpose: self-checking bench of the bit/flag/stack execution unit
// Assumes: zero-wait apb slave, one idle cycle between transfers
// Notes:   rows are {op, bit, operand, flags in, result, flags out}
`timescale 1ns/1ns
`default_nettype none

module test_bfsx_exec_unit;
  logic        clk_sys, nrst, clk_en, debug_active, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r; // r holds prdata of the last transfer, zero after a write
  logic        pready, pslverr, sleep_req, wdog_restart, break_req, e;
  logic [39:0] rows [12];         // datapath cases
  int          mismatches, checks;

  bfsx_exec_unit i_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .debug_active(debug_active), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .wdog_restart(wdog_restart), .break_req(break_req));

  // free-running 125 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail($sformatf("bit %b expected %b", got, exp));
  endtask : chk_bit

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      fail("no ready");
      tally_and_finish();
    end
  endtask : apb

  function automatic logic [31:0] cmd(input logic [4:0] op, input logic [2:0] b,
                                      input logic [1:0] s, input logic [7:0] d);
    return {8'h00, d, 2'b00, s, 1'b0, b, 3'b000, op};
  endfunction : cmd

  // control op, then pulses {sleep, wdog, break} in the next cycle
  task automatic pulse(input logic [4:0] op, input logic [2:0] exp);
    apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(op, 3'h0, 2'h0, 8'h00));
    @(negedge clk_sys);
    chk_byte({5'h00, sleep_req, wdog_restart, break_req}, {5'h00, exp});
  endtask : pulse

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail("timeout");
    tally_and_finish();
  end

  initial
  begin
    {nrst, debug_active, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    mismatches = 0;
    checks = 0;
    rows = '{{5'h05,3'h0,8'h81,8'h00,8'h02,8'h19}, {5'h05,3'h0,8'h80,8'he0,8'h00,8'hfb},
             {5'h06,3'h0,8'h01,8'h00,8'h00,8'h1b}, {5'h06,3'h0,8'hfe,8'h1f,8'h7f,8'h00},
             {5'h07,3'h0,8'h40,8'h01,8'h81,8'h0c}, {5'h08,3'h0,8'h01,8'h01,8'h80,8'h15},
             {5'h09,3'h0,8'h81,8'h00,8'hc0,8'h15}, {5'h0a,3'h0,8'h3c,8'h55,8'hc3,8'h55},
             {5'h0b,3'h5,8'h20,8'h00,8'h00,8'h40}, {5'h0b,3'h2,8'hfb,8'hff,8'h00,8'hbf},
             {5'h0c,3'h7,8'h00,8'h40,8'h80,8'h40}, {5'h0c,3'h0,8'hff,8'h00,8'hfe,8'h00}};
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    // datapath rows: flags in, command, result and flags out
    foreach (rows[i])
    begin
      apb(1'b1, bfsx_pkg::ADDR_FLAGS, {24'h0, rows[i][23:16]});
      apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(rows[i][39:35], rows[i][34:32], 2'h0, rows[i][31:24]));
      apb(1'b0, bfsx_pkg::ADDR_RESULT, 32'h0);
      if (rows[i][39:35] != 5'h0b) chk_byte(r[7:0], rows[i][15:8]);
      apb(1'b0, bfsx_pkg::ADDR_FLAGS, 32'h0);
      chk_byte(r[7:0], rows[i][7:0]);
    end
    // every flag index set from zero and cleared from all ones
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, bfsx_pkg::ADDR_FLAGS, 32'h0);
      apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h0d, k[2:0], 2'h0, 8'h00));
      apb(1'b0, bfsx_pkg::ADDR_FLAGS, 32'h0);
      chk_byte(r[7:0], 8'h01 << k);
      apb(1'b1, bfsx_pkg::ADDR_FLAGS, 32'hff);
      apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h0e, k[2:0], 2'h0, 8'h00));
      apb(1'b0, bfsx_pkg::ADDR_FLAGS, 32'h0);
      chk_byte(r[7:0], ~(8'h01 << k));
    end
    // stack last in first out, flags kept
    apb(1'b1, bfsx_pkg::ADDR_FLAGS, 32'h5a);
    apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h01, 3'h0, 2'h0, 8'ha5));
    apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h01, 3'h0, 2'h0, 8'h3c));
    apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h02, 3'h0, 2'h0, 8'h00));
    apb(1'b0, bfsx_pkg::ADDR_RESULT, 32'h0);
    chk_byte(r[7:0], 8'h3c);
    apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h02, 3'h0, 2'h0, 8'h00));
    apb(1'b0, bfsx_pkg::ADDR_RESULT, 32'h0);
    chk_byte(r[7:0], 8'ha5);
    // io bit clear and set in two different registers
    apb(1'b1, 8'h14, 32'hff);
    apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h04, 3'h0, 2'h1, 8'h00));
    apb(1'b1, bfsx_pkg::ADDR_CMD, cmd(5'h03, 3'h3, 2'h2, 8'h00));
    apb(1'b0, 8'h14, 32'h0);
    chk_byte(r[7:0], 8'hfe);
    apb(1'b0, 8'h18, 32'h0);
    chk_byte(r[7:0], 8'h08);
    apb(1'b0, bfsx_pkg::ADDR_FLAGS, 32'h0);
    chk_byte(r[7:0], 8'h5a);
    // control pulses, break only under debug
    pulse(5'h0f, 3'b100);
    pulse(5'h10, 3'b010);
    pulse(5'h11, 3'b000);
    debug_active <= 1'b1;
    pulse(5'h11, 3'b001);
    pulse(5'h00, 3'b000);
    apb(1'b0, bfsx_pkg::ADDR_FLAGS, 32'h0);
    chk_byte(r[7:0], 8'h5a);
    // unmapped address flagged
    apb(1'b0, 8'h40, 32'h0);
    chk_bit(e, 1'b1);
    // write lost while the clock enable is low
    clk_en <= 1'b0;
    apb(1'b1, bfsx_pkg::ADDR_FLAGS, 32'h77);
    clk_en <= 1'b1;
    apb(1'b0, bfsx_pkg::ADDR_FLAGS, 32'h0);
    chk_byte(r[7:0], 8'h5a);
    // mid-run reset clears flags and io registers
    apb(1'b1, bfsx_pkg::ADDR_IO, 32'hff);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(1'b0, bfsx_pkg::ADDR_FLAGS, 32'h0);
    chk_byte(r[7:0], bfsx_pkg::FLAGS_RST);
    apb(1'b0, bfsx_pkg::ADDR_IO, 32'h0);
    chk_byte(r[7:0], bfsx_pkg::IO_RST);
    tally_and_finish();
  end
endmodule : test_bfsx_exec_unit
`default_nettype wire
